//--- sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Register offsets (byte addresses from the block base)
`define SDC_BASE_ADDR      32'hFFFF2000
`define SDC_OFF_MAIN       12'h000
`define SDC_OFF_BUF        12'h004
`define SDC_OFF_REF        12'h008
`define SDC_OFF_WBT        12'h00C

// Main configuration field positions
`define SDC_AP_BIT         24
`define SDC_RCD_HI         23
`define SDC_RCD_LO         22
`define SDC_CL_HI          21
`define SDC_CL_LO          20
`define SDC_X16_BIT        19
`define SDC_CKE_ON_BIT     18
`define SDC_CLK_STOP_BIT   17
`define SDC_CS1_BANK_BIT   7
`define SDC_CS1_X8_BIT     6
`define SDC_CS1_BIG_BIT    5
`define SDC_CS0_BANK_BIT   3
`define SDC_CS0_X8_BIT     2
`define SDC_CS0_BIG_BIT    1

// Writable bits and reset values
`define SDC_MAIN_MASK      32'h01FE00EE
`define SDC_MAIN_RESET     32'h01F00000
`define SDC_BUF_MASK       32'h0000000F
`define SDC_BUF_RESET      32'h0000000C
`define SDC_BUSY_BIT       5
`define SDC_REF_MASK       32'h0000FFFF
`define SDC_REF_RESET      32'h00000080
`define SDC_WBT_MASK       32'h0000FFFF
`define SDC_WBT_RESET      32'h00000000

`endif

//--- sdc_pkg.sv
package sdc_pkg;

  // Decoded view of the main configuration register
  typedef struct packed {
    logic       autoPrecharge;
    logic [1:0] rasCasDelaySel;
    logic [1:0] casLatencySel;
    logic       busHalfWidth;
    logic       clockEnableAlwaysOn;
    logic       clockStopEnable;
    logic       cs1FourBanks;
    logic       cs1ByteWideMux;
    logic       cs1LargeDeviceMux;
    logic       cs0FourBanks;
    logic       cs0ByteWideMux;
    logic       cs0LargeDeviceMux;
  } sdc_main_s;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } sdc_wb_req_s;

  typedef enum logic [1:0] {
    SDC_REG_MAIN,
    SDC_REG_BUF,
    SDC_REG_REF,
    SDC_REG_WBT
  } sdc_reg_e;

endpackage

//--- sdc_reg.sv
`timescale 1ns/1ns
// One 32-bit register with byte-lane writes and a writable-bit mask
module sdc_reg #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITE_MASK  = 32'hFFFFFFFF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] wrData,
  output logic      [31:0] value
);
  logic [31:0] laneMask;
  logic [31:0] next_value;

  // Byte lanes merge with held value; fixed bits stay at reset value
  assign laneMask   = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & WRITE_MASK;
  assign next_value = (value & ~laneMask) | (wrData & laneMask);

  // ************************************************************
  // Storage
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      value <= RESET_VALUE;
    else if (wrEn)
      value <= next_value;
  end
endmodule

//--- sdc_clk_gate.sv
`timescale 1ns/1ns
// Memory clock and clock-enable for one device group
module sdc_clk_gate (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clockEnableAlwaysOn,
  input  wire logic clockStopEnable,
  input  wire logic csIdle,
  input  wire logic allIdle,
  output logic      cke,
  output logic      clkRun
);
  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cke    <= 1'b1;
      clkRun <= 1'b1;
    end
    else
    begin
      cke    <= clockEnableAlwaysOn | ~csIdle;
      clkRun <= ~(clockStopEnable & allIdle);
    end
  end
endmodule

//--- sdram_ctrl_config.sv
`timescale 1ns/1ns
`include "sdc_cfg.svh"
module sdram_ctrl_config (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire sdc_pkg::sdc_wb_req_s wbReq,
  output logic                     wbAck,
  output logic               [31:0] wbDatOut,
  input  wire logic                cs0Busy,
  input  wire logic                cs1Busy,
  output sdc_pkg::sdc_main_s       mainCfg,
  output logic                     writeBufferEn,
  output logic                     readBufferEn,
  output logic               [1:0] initCommand,
  output logic              [15:0] refreshInterval,
  output logic              [15:0] writeBufferFlushDelay,
  output logic                     memClockEnable0,
  output logic                     memClockEnable1,
  output logic                     memClockRun
);
  import sdc_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  localparam logic [31:0] BASE = `SDC_BASE_ADDR;

  logic        request;
  logic [31:0] busAddr;
  logic        hitMain;
  logic        hitBuf;
  logic        hitRef;
  logic        hitWbt;
  logic        writeStrobe;
  logic [31:0] mainValue;
  logic [31:0] bufValue;
  logic [31:0] refValue;
  logic [31:0] wbtValue;
  logic [31:0] readMux;
  logic [31:0] bufView;
  logic        ctrlBusy;
  logic        cs0BusySync1;
  logic        cs0BusySync2;
  logic        cs1BusySync1;
  logic        cs1BusySync2;
  logic        cke0Raw;
  logic        cke1Raw;
  logic        runRaw0;
  logic        runRaw1;

  // A request is taken only when ack is low, giving one answer per access
  assign request     = wbReq.cyc & wbReq.stb & ~wbAck;
  assign writeStrobe = request & wbReq.we;

  // Full system address; only the low twelve bits travel on the bus, the rest is the fixed base
  assign busAddr = {BASE[31:12], wbReq.adr};

  // Word-aligned decode; byte enables select lanes
  assign hitMain = busAddr[31:2] == 30'((BASE + {20'h00000, `SDC_OFF_MAIN}) >> 2);
  assign hitBuf  = busAddr[31:2] == 30'((BASE + {20'h00000, `SDC_OFF_BUF}) >> 2);
  assign hitRef  = busAddr[31:2] == 30'((BASE + {20'h00000, `SDC_OFF_REF}) >> 2);
  assign hitWbt  = busAddr[31:2] == 30'((BASE + {20'h00000, `SDC_OFF_WBT}) >> 2);

  // ************************************************************
  // Status inputs
  // ************************************************************
  // Busy comes from the command engine, treated as asynchronous for safety
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs0BusySync1 <= 1'b0;
      cs0BusySync2 <= 1'b0;
      cs1BusySync1 <= 1'b0;
      cs1BusySync2 <= 1'b0;
    end
    else
    begin
      cs0BusySync1 <= cs0Busy;
      cs0BusySync2 <= cs0BusySync1;
      cs1BusySync1 <= cs1Busy;
      cs1BusySync2 <= cs1BusySync1;
    end
  end

  assign ctrlBusy = cs0BusySync2 | cs1BusySync2;

  // ************************************************************
  // Registers
  // ************************************************************
  // Reserved bits are masked out so they hold zero whatever software writes
  sdc_reg #(
    .RESET_VALUE (`SDC_MAIN_RESET),
    .WRITE_MASK  (`SDC_MAIN_MASK)
  ) u_main (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (writeStrobe & hitMain),
    .sel    (wbReq.sel),
    .wrData (wbReq.dat),
    .value  (mainValue)
  );

  sdc_reg #(
    .RESET_VALUE (`SDC_BUF_RESET),
    .WRITE_MASK  (`SDC_BUF_MASK)
  ) u_buf (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (writeStrobe & hitBuf),
    .sel    (wbReq.sel),
    .wrData (wbReq.dat),
    .value  (bufValue)
  );

  sdc_reg #(
    .RESET_VALUE (`SDC_REF_RESET),
    .WRITE_MASK  (`SDC_REF_MASK)
  ) u_ref (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (writeStrobe & hitRef),
    .sel    (wbReq.sel),
    .wrData (wbReq.dat),
    .value  (refValue)
  );

  sdc_reg #(
    .RESET_VALUE (`SDC_WBT_RESET),
    .WRITE_MASK  (`SDC_WBT_MASK)
  ) u_wbt (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (writeStrobe & hitWbt),
    .sel    (wbReq.sel),
    .wrData (wbReq.dat),
    .value  (wbtValue)
  );

  // Busy bit is read-only and reflects live controller state
  assign bufView = bufValue | ({31'h00000000, ctrlBusy} << `SDC_BUSY_BIT);

  // Unmapped offsets inside the window read as zero and still acknowledge
  assign readMux = hitMain ? mainValue :
                   hitBuf  ? bufView :
                   hitRef  ? refValue :
                   hitWbt  ? wbtValue : 32'h00000000;

  // ************************************************************
  // Bus answer: one wait-free cycle after the request
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h00000000;
    end
    else
    begin
      wbAck <= request;
      if (request & ~wbReq.we)
        wbDatOut <= readMux;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  assign mainCfg.autoPrecharge       = mainValue[`SDC_AP_BIT];
  assign mainCfg.rasCasDelaySel      = mainValue[`SDC_RCD_HI:`SDC_RCD_LO];
  assign mainCfg.casLatencySel       = mainValue[`SDC_CL_HI:`SDC_CL_LO];
  assign mainCfg.busHalfWidth        = mainValue[`SDC_X16_BIT];
  assign mainCfg.clockEnableAlwaysOn = mainValue[`SDC_CKE_ON_BIT];
  assign mainCfg.clockStopEnable     = mainValue[`SDC_CLK_STOP_BIT];
  assign mainCfg.cs1FourBanks        = mainValue[`SDC_CS1_BANK_BIT];
  assign mainCfg.cs1ByteWideMux      = mainValue[`SDC_CS1_X8_BIT];
  assign mainCfg.cs1LargeDeviceMux   = mainValue[`SDC_CS1_BIG_BIT];
  assign mainCfg.cs0FourBanks        = mainValue[`SDC_CS0_BANK_BIT];
  assign mainCfg.cs0ByteWideMux      = mainValue[`SDC_CS0_X8_BIT];
  assign mainCfg.cs0LargeDeviceMux   = mainValue[`SDC_CS0_BIG_BIT];

  assign writeBufferEn         = bufValue[3];
  assign readBufferEn          = bufValue[2];
  assign initCommand           = bufValue[1:0];
  assign refreshInterval       = refValue[15:0];
  assign writeBufferFlushDelay = wbtValue[15:0];

  // ************************************************************
  // Memory clock and clock-enable control
  // ************************************************************
  // Both gates see the same stop condition; the shared clock runs only while both ask
  sdc_clk_gate u_gate0 (
    .clk                 (clk),
    .rst                 (rst),
    .clockEnableAlwaysOn (mainCfg.clockEnableAlwaysOn),
    .clockStopEnable     (mainCfg.clockStopEnable),
    .csIdle              (~cs0BusySync2),
    .allIdle             (~ctrlBusy),
    .cke                 (cke0Raw),
    .clkRun              (runRaw0)
  );

  sdc_clk_gate u_gate1 (
    .clk                 (clk),
    .rst                 (rst),
    .clockEnableAlwaysOn (mainCfg.clockEnableAlwaysOn),
    .clockStopEnable     (mainCfg.clockStopEnable),
    .csIdle              (~cs1BusySync2),
    .allIdle             (~ctrlBusy),
    .cke                 (cke1Raw),
    .clkRun              (runRaw1)
  );

  assign memClockEnable0 = cke0Raw;
  assign memClockEnable1 = cke1Raw;
  assign memClockRun     = runRaw0 & runRaw1;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_ack_follows;
    @(posedge clk) disable iff (rst)
      (wbReq.cyc & wbReq.stb & ~wbAck) |=> wbAck;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");

  property p_ack_one;
    @(posedge clk) disable iff (rst)
      wbAck |=> ~wbAck;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");

  property p_main_reset;
    @(posedge clk)
      rst |=> (mainValue == `SDC_MAIN_RESET);
  endproperty
  a_main_reset: assert property (p_main_reset) else $error("bad main reset");

  property p_main_write;
    @(posedge clk) disable iff (rst)
      (writeStrobe & hitMain & (wbReq.sel == 4'hF)) |=>
        (mainValue == ($past(wbReq.dat) & `SDC_MAIN_MASK));
  endproperty
  a_main_write: assert property (p_main_write) else $error("main write lost");

  property p_main_read;
    @(posedge clk) disable iff (rst)
      (request & ~wbReq.we & hitMain) |=> (wbDatOut == $past(mainValue));
  endproperty
  a_main_read: assert property (p_main_read) else $error("main read wrong");

  property p_busy_read;
    @(posedge clk) disable iff (rst)
      (request & ~wbReq.we & hitBuf) |=> (wbDatOut[5] == $past(ctrlBusy));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

  property p_cke_on;
    @(posedge clk) disable iff (rst)
      mainCfg.clockEnableAlwaysOn ##1 mainCfg.clockEnableAlwaysOn |-> memClockEnable0 & memClockEnable1;
  endproperty
  a_cke_on: assert property (p_cke_on) else $error("cke dropped");

  property p_cke_idle;
    @(posedge clk) disable iff (rst)
      (~mainCfg.clockEnableAlwaysOn & ~cs0BusySync2) |=> ~memClockEnable0;
  endproperty
  a_cke_idle: assert property (p_cke_idle) else $error("idle cke high");

  property p_clk_run;
    @(posedge clk) disable iff (rst)
      ~mainCfg.clockStopEnable |=> memClockRun;
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock stopped");

  property p_clk_stop;
    @(posedge clk) disable iff (rst)
      (mainCfg.clockStopEnable & ~ctrlBusy) |=> ~memClockRun;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock not stopped");

  property p_unmapped_read;
    @(posedge clk) disable iff (rst)
      (request & ~wbReq.we & ~(hitMain | hitBuf | hitRef | hitWbt)) |=> (wbDatOut == 32'h00000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_busy_sync;
    @(posedge clk) disable iff (rst)
      ctrlBusy == ($past(cs0Busy, 2) | $past(cs1Busy, 2));
  endproperty
  a_busy_sync: assert property (p_busy_sync) else $error("busy status late");
endmodule

//--- sdc_mem_model.sv
`timescale 1ns/1ns
// ****************************************
// Memory engines behind the two chip selects
// ****************************************
module sdc_mem_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic goBusy0,
  input  wire logic goBusy1,
  output logic      cs0Busy,
  output logic      cs1Busy
);
  // Busy shows one cycle after work starts, so the block never sees it early
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs0Busy <= 1'b0;
      cs1Busy <= 1'b0;
    end
    else
    begin
      cs0Busy <= goBusy0;
      cs1Busy <= goBusy1;
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ns
// ****************************************
// Bench for the memory configuration block
// ****************************************
module testbench;
  import sdc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  sdc_wb_req_s wbReq = '0;
  logic        wbAck;
  logic [31:0] wbDatOut;
  logic        cs0Busy;
  logic        cs1Busy;
  logic        goBusy0 = 1'b0;
  logic        goBusy1 = 1'b0;
  sdc_main_s   mainCfg;
  logic        writeBufferEn;
  logic        readBufferEn;
  logic [1:0]  initCommand;
  logic [15:0] refreshInterval;
  logic [15:0] writeBufferFlushDelay;
  logic        memClockEnable0;
  logic        memClockEnable1;
  logic        memClockRun;
  logic [31:0] mainExp;
  logic [31:0] rdata;
  int          errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  sdram_ctrl_config u_dut (
    .clk                   (clk),
    .rst                   (rst),
    .wbReq                 (wbReq),
    .wbAck                 (wbAck),
    .wbDatOut              (wbDatOut),
    .cs0Busy               (cs0Busy),
    .cs1Busy               (cs1Busy),
    .mainCfg               (mainCfg),
    .writeBufferEn         (writeBufferEn),
    .readBufferEn          (readBufferEn),
    .initCommand           (initCommand),
    .refreshInterval       (refreshInterval),
    .writeBufferFlushDelay (writeBufferFlushDelay),
    .memClockEnable0       (memClockEnable0),
    .memClockEnable1       (memClockEnable1),
    .memClockRun           (memClockRun)
  );

  sdc_mem_model u_mem (
    .clk     (clk),
    .rst     (rst),
    .goBusy0 (goBusy0),
    .goBusy1 (goBusy1),
    .cs0Busy (cs0Busy),
    .cs1Busy (cs1Busy)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle; waits for ack however long it takes, only the hang guard ends a wait
  task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    do
    begin
      @(posedge clk);
    end
    while (wbAck !== 1'b1);
    rdata = wbDatOut;
    wbReq <= '0;
  endtask

  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h00000000, 4'hF);
    check(rdata, exp);
  endtask

  // Main writes wait for idle first; reserved bits read back as zero
  task automatic wr_main(input logic [31:0] v, input logic [3:0] sel);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, 12'h004, 32'h00000000, 4'hF);
      n++;
    end
    while (rdata[5] !== 1'b0 && n < 40);
    check({31'h0, rdata[5]}, 32'h00000000);
    xfer(1'b1, 12'h000, v, sel);
    for (int b = 0; b < 4; b++)
      if (sel[b])
        mainExp[8*b +: 8] = v[8*b +: 8] & 8'(32'h01FE00EE >> (8 * b));
  endtask

  function automatic logic [13:0] fields(input logic [31:0] v);
    return {v[24:17], v[7:5], v[3:1]};
  endfunction

  // Drive engine activity, let it cross the synchroniser, then look at the pins
  task automatic busy_step(input logic b0, input logic b1, input logic [2:0] exp);
    @(posedge clk);
    goBusy0 <= b0;
    goBusy1 <= b1;
    repeat (6) @(posedge clk);
    check({29'h0, memClockRun, memClockEnable0, memClockEnable1}, {29'h0, exp});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(12'h000, 32'h01F00000);
    check({18'h0, mainCfg}, {18'h0, fields(32'h01F00000)});
    rd_chk(12'h004, 32'h0000000C);
    rd_chk(12'h008, 32'h00000080);
    rd_chk(12'h00C, 32'h00000000);
    check({29'h0, memClockRun, memClockEnable0, memClockEnable1}, 32'h4);
    $display("test reset done");
  endtask

  // Every legal latency code, each chip-select option on and off
  task automatic t_codes();
    logic [1:0] rcdTab [3];
    logic [1:0] clTab [3];
    logic [7:0] lowTab [3];
    rcdTab = '{2'b10, 2'b11, 2'b10};
    clTab = '{2'b01, 2'b10, 2'b11};
    lowTab = '{8'hA4, 8'h4A, 8'hEE};
    for (int i = 0; i < 3; i++)
    begin
      wr_main({7'h00, i[0], rcdTab[i], clTab[i], i[0], 11'h000, lowTab[i]}, 4'hF);
      rd_chk(12'h000, mainExp);
      check({18'h0, mainCfg}, {18'h0, fields(mainExp)});
    end
    $display("test codes done");
  endtask

  // Byte and half-word writes touch only their lanes
  task automatic t_lanes();
    wr_main(32'h00000000, 4'h8);
    rd_chk(12'h000, mainExp);
    wr_main(32'h000000EE, 4'h3);
    rd_chk(12'h000, mainExp);
    wr_main(32'h00AA0000, 4'h4);
    rd_chk(12'h000, mainExp);
    xfer(1'b1, 12'h010, 32'hFFFFFFFF, 4'hF);
    rd_chk(12'h010, 32'h00000000);
    rd_chk(12'h000, mainExp);
    $display("test lanes done");
  endtask

  // Other registers; status bit ignores writes
  task automatic t_others();
    xfer(1'b1, 12'h004, 32'h00000027, 4'hF);
    rd_chk(12'h004, 32'h00000007);
    check({28'h0, writeBufferEn, readBufferEn, initCommand}, 32'h7);
    xfer(1'b1, 12'h004, 32'h0000000C, 4'h1);
    xfer(1'b1, 12'h008, 32'h00000320, 4'hF);
    rd_chk(12'h008, 32'h00000320);
    check({16'h0, refreshInterval}, 32'h320);
    xfer(1'b1, 12'h00C, 32'h00001234, 4'h3);
    rd_chk(12'h00C, 32'h00001234);
    check({16'h0, writeBufferFlushDelay}, 32'h1234);
    $display("test others done");
  endtask

  // Clock enable and memory clock against activity, all three legal modes
  task automatic t_clock();
    wr_main(mainExp & 32'hFFF9FFFF, 4'hF);
    busy_step(1'b1, 1'b0, 3'b110);
    rd_chk(12'h004, 32'h0000002C);
    busy_step(1'b0, 1'b0, 3'b100);
    wr_main(mainExp | 32'h00020000, 4'hF);
    busy_step(1'b0, 1'b0, 3'b000);
    busy_step(1'b0, 1'b1, 3'b101);
    rd_chk(12'h004, 32'h0000002C);
    busy_step(1'b0, 1'b0, 3'b000);
    wr_main((mainExp & 32'hFFFDFFFF) | 32'h00040000, 4'hF);
    busy_step(1'b0, 1'b0, 3'b111);
    $display("test clock done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reset for four cycles, then the scenarios in order
  initial
  begin
    mainExp = 32'h01F00000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_codes();
    t_lanes();
    t_others();
    t_clock();
    wrap_up();
  end
endmodule
